// File: hdl/wsc_pkg.sv
// Constants for the window strobe control register: field layout, reset
// values and synchroniser depth. Shared by the core and the link-side shift stage.
//
// Contract
// RQ1 - Bits zero to four form the strobe word setting window displacement.
// RQ2 - Bit five must be zero normally; one selects production test mode.
// RQ3 - Host loads only at initialization or between reads, never mid-read.
// RQ4 - Load enable low: serial data shifts in, holding latch keeps value.
// RQ5 - Hardwired use: each encoded read pulse shifts one bit in.
// RQ6 - Load enable high: shifting stops, shift stage copies into latch.
// RQ7 - Zero data with enable on read gate gives all-zero word at gate.
// RQ8 - Outside logic holds read gate low, pulses data in, then raises it.
// RQ9 - Bit four is sign, early zero late one; zero magnitude means none.
// RQ10 - Test bit is shifted in first on every load.
// RQ11 - Host changes strobe only with read gate low, then allows settling.
// RQ12 - After test bit, bits four down to zero follow, one per clock.

package wsc_pkg;

    localparam int          WSC_WORD_W    = 6;
    localparam int          WSC_STROBE_W  = 5;
    localparam int          WSC_MAG_W     = 4;
    localparam int          WSC_TEST_BIT  = 5;
    localparam int          WSC_SIGN_BIT  = 4;
    localparam int          WSC_MAG_MSB   = 3;
    localparam int          WSC_SYNC_FF   = 3;

    localparam logic [5:0]  WSC_WORD_RST  = 6'h00;
    localparam logic [4:0]  WSC_STRB_RST  = 5'h00;
    localparam logic [3:0]  WSC_MAG_ZERO  = 4'h0;
    localparam logic [2:0]  WSC_CNT_FULL  = 3'h6;
    localparam logic [2:0]  WSC_CNT_RST   = 3'h0;

    // Sign bit encoding of displacement direction
    localparam logic        WSC_SIGN_EARLY = 1'b0;
    localparam logic        WSC_SIGN_LATE  = 1'b1;

endpackage

// File: hdl/wsc_shift_stage.sv
// Serial shift stage of the control register, clocked by the link clock.
// Assumes data and load enable are driven synchronously to the link clock,
// which may be the shift clock of a serial bus or the encoded read pulses.
`timescale 1ns/1ps

module wsc_shift_stage
    import wsc_pkg::*;
(
    input  wire logic                  link_clk,  // Shift clock or read pulses
    input  wire logic                  rst_n,     // Async reset, active low
    input  wire logic                  load_en,   // High freezes the stage
    input  wire logic                  ser_in,    // Serial data bit
    output logic [wsc_pkg::WSC_WORD_W-1:0] word,  // Shift stage contents
    output logic                       full       // Six or more shifts since enable was last seen high at a link edge
);
    import wsc_pkg::*;

    logic [2:0] cnt_reg;
    logic       fresh_reg;

    // Bit five lands in the top position after six shifts: first in, first out
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            word <= WSC_WORD_RST;
        end else if (!load_en) begin
            word <= {word[WSC_WORD_W-2:0], ser_in}; // RQ4 RQ5 RQ10 RQ12
        end
    end

    // Count restarts on the first shift after enable was seen high at a link edge. Enable high is seen
    // only at a link edge, so with the link stopped between frames the count
    // stays saturated: a short frame is flagged only after such an edge.
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg   <= WSC_CNT_RST;
            fresh_reg <= 1'b1;
        end else if (load_en) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
            if (fresh_reg) begin
                cnt_reg <= 3'h1;
            end else if (cnt_reg != WSC_CNT_FULL) begin
                cnt_reg <= cnt_reg + 3'h1;
            end
        end
    end

    assign full = (cnt_reg == WSC_CNT_FULL);

    AST_SHIFT_IN: assert property (@(posedge link_clk) disable iff (!rst_n) // RQ4
        !load_en |=> (word == {$past(word[WSC_WORD_W-2:0]), $past(ser_in)}))
        else $error("shift stage did not take serial bit");

    AST_SHIFT_FREEZE: assert property (@(posedge link_clk) disable iff (!rst_n) // RQ6
        load_en |=> $stable(word))
        else $error("shift stage moved while load enable high");

    AST_FIRST_BIT_TOP: assert property (@(posedge link_clk) disable iff (!rst_n) // RQ10
        (load_en ##1 !load_en [*6]) |=> (word[WSC_TEST_BIT] == $past(ser_in, 6)))
        else $error("first shifted bit not in test position");
endmodule // wsc_shift_stage

// File: hdl/wsc_strobe_ctrl.sv
// Window strobe control register: link-side shift stage plus core-side
// holding latch and decoded strobe outputs.
// Assumes the loading party pulses the link clock only with load enable low
// and keeps load enable high while a read is in progress.
`timescale 1ns/1ps

module wsc_strobe_ctrl
    import wsc_pkg::*;
#(
    parameter int WORD_W = wsc_pkg::WSC_WORD_W // Control register width
) (
    input  wire logic                  CORE_CLK,       // 25 MHz core clock
    input  wire logic                  RESET_N,        // Async reset
    input  wire logic                  LINK_CLK,       // Shift clock / read pulses
    input  wire logic                  SERIAL_DATA,    // Serial data in
    input  wire logic                  REGISTER_LOAD_ENABLE, // Low loads, high latches
    output logic [wsc_pkg::WSC_STROBE_W-1:0] STROBE_WORD, // Latched bits four..zero
    output logic                       STROBE_SIGN,    // Zero early, one late
    output logic [wsc_pkg::WSC_MAG_W-1:0] STROBE_MAG,  // Displacement magnitude
    output logic                       DISPLACE_EARLY, // Window moved early
    output logic                       DISPLACE_LATE,  // Window moved late
    output logic                       TEST_MODE,      // Production test mode
    output logic                       LOAD_COMPLETE,  // Latched at transfer: six or more shifts since enable was last seen high at a link edge
    output logic                       LATCH_UPDATE    // One-cycle transfer pulse
);
    import wsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check

    if (WORD_W != WSC_WORD_W) begin : g_bad_width
        $error("WORD_W must equal the six-bit control register width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain

    logic [WSC_WORD_W-1:0] shift_word;
    logic                  shift_full;

    wsc_shift_stage u_shift (
        .link_clk (LINK_CLK),
        .rst_n    (RESET_N),
        .load_en  (REGISTER_LOAD_ENABLE),
        .ser_in   (SERIAL_DATA),
        .word     (shift_word),
        .full     (shift_full)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Crossing
    // Load enable is the handshake: once it is high the link side has stopped,
    // so the shift word is static by the time the filtered level reaches here.

    logic load_en_sync;
    logic load_en_prev_reg;

    wsc_sync3 u_sync_en (
        .clk     (CORE_CLK),
        .rst_n   (RESET_N),
        .d_async (REGISTER_LOAD_ENABLE),
        .q_filt  (load_en_sync)
    );

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            load_en_prev_reg <= 1'b0;
        end else begin
            load_en_prev_reg <= load_en_sync;
        end
    end

    wire transfer = load_en_sync & ~load_en_prev_reg; // RQ6

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the incoming word

    wire [WSC_STROBE_W-1:0] strobe_next = shift_word[WSC_STROBE_W-1:0];    // RQ1
    wire                    sign_next   = shift_word[WSC_SIGN_BIT];        // RQ9
    wire [WSC_MAG_W-1:0]    mag_next    = shift_word[WSC_MAG_MSB:0];       // RQ9
    wire                    test_next   = shift_word[WSC_TEST_BIT];        // RQ2
    wire                    mag_nonzero = (mag_next != WSC_MAG_ZERO);

    // Zero magnitude moves nothing whatever the sign
    wire early_next = mag_nonzero & (sign_next == WSC_SIGN_EARLY);         // RQ9
    wire late_next  = mag_nonzero & (sign_next == WSC_SIGN_LATE);          // RQ9

    ////////////////////////////////////////////////////////////////////////////
    // Holding latch
    // Updated only on the rising enable; while enable is low it holds, so a
    // read in progress keeps its window however the shift stage moves.

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            STROBE_WORD <= WSC_STRB_RST;
            STROBE_SIGN <= WSC_SIGN_EARLY;
            STROBE_MAG  <= WSC_MAG_ZERO;
            TEST_MODE   <= 1'b0;
        end else if (transfer) begin
            STROBE_WORD <= strobe_next;   // RQ1 RQ6 RQ7
            STROBE_SIGN <= sign_next;     // RQ9
            STROBE_MAG  <= mag_next;      // RQ9
            TEST_MODE   <= test_next;     // RQ2
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DISPLACE_EARLY <= 1'b0;
            DISPLACE_LATE  <= 1'b0;
            LOAD_COMPLETE  <= 1'b0;
        end else if (transfer) begin
            DISPLACE_EARLY <= early_next; // RQ9
            DISPLACE_LATE  <= late_next;  // RQ9
            LOAD_COMPLETE  <= shift_full;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            LATCH_UPDATE <= 1'b0;
        end else begin
            LATCH_UPDATE <= transfer;     // RQ6
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_LATCH_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // RQ4
        !load_en_sync |=> $stable(STROBE_WORD) && $stable(TEST_MODE))
        else $error("holding latch changed while load enable low");

    AST_TRANSFER_WORD: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // RQ6
        transfer |=> (STROBE_WORD == $past(shift_word[WSC_STROBE_W-1:0]))
                     && LATCH_UPDATE)
        else $error("shift stage not copied on rising load enable");

    AST_TEST_BIT: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // RQ2
        transfer |=> (TEST_MODE == $past(shift_word[WSC_TEST_BIT])))
        else $error("test mode does not follow bit five");

    AST_FIELDS: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // RQ1
        STROBE_WORD == {STROBE_SIGN, STROBE_MAG})
        else $error("strobe word and fields disagree");

    AST_NO_DISPLACE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // RQ9
        (STROBE_MAG == WSC_MAG_ZERO) |-> !DISPLACE_EARLY && !DISPLACE_LATE)
        else $error("displacement flagged with zero magnitude");

    AST_DIRECTION: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // RQ9
        (STROBE_MAG != WSC_MAG_ZERO) |->
            (DISPLACE_LATE == STROBE_SIGN) && (DISPLACE_EARLY == !STROBE_SIGN))
        else $error("direction does not follow sign bit");

    AST_ZERO_LOAD: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // RQ7
        (transfer && shift_word == WSC_WORD_RST) |=>
            (STROBE_WORD == WSC_STRB_RST) && !TEST_MODE && !DISPLACE_LATE
            && !DISPLACE_EARLY)
        else $error("all-zero load did not give nominal strobe");

    AST_PULSE_ONE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // RQ6
        LATCH_UPDATE |=> !LATCH_UPDATE)
        else $error("latch update pulse longer than one cycle");

    AST_ENABLE_LATENCY: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // RQ6
        ($rose(REGISTER_LOAD_ENABLE) ##1 REGISTER_LOAD_ENABLE [*6]) |->
            ##[0:1] load_en_prev_reg)
        else $error("load enable rise not seen within synchroniser delay");

    COV_TRANSFER: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
        LATCH_UPDATE && LOAD_COMPLETE);

    COV_LATE: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
        LATCH_UPDATE && DISPLACE_LATE);

    COV_EARLY: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
        LATCH_UPDATE && DISPLACE_EARLY);

    COV_TEST: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
        LATCH_UPDATE && TEST_MODE);
endmodule // wsc_strobe_ctrl

// File: hdl/wsc_sync3.sv
// Three-flop input synchroniser with agreement filter.
// Assumes an asynchronous level input; output changes only when stages two
// and three agree, so a one-cycle glitch past the first stage is dropped.
`timescale 1ns/1ps

module wsc_sync3 (
    input  wire logic clk,      // Destination clock
    input  wire logic rst_n,    // Async reset, active low
    input  wire logic d_async,  // Level from another domain
    output logic      q_filt    // Filtered synchronised level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_filt <= 1'b0;
        end else begin
            s1_reg <= d_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                q_filt <= s3_reg;
            end
        end
    end
endmodule // wsc_sync3

// File: tb/tb_wsc_strobe_ctrl.sv
// Self-checking bench for the strobe control register.
// Assumes the host model drives the link and the bench drives core reset.
`timescale 1ns/1ps

module tb_wsc_strobe_ctrl;
    import wsc_pkg::*;
    logic CORE_CLK = 1'b0;
    logic RESET_N  = 1'b0;
    wire  lclk, sdat, len;
    wire  [4:0] STROBE_WORD;
    wire  [3:0] STROBE_MAG;
    wire  STROBE_SIGN, DISPLACE_EARLY, DISPLACE_LATE;
    wire  TEST_MODE, LOAD_COMPLETE, LATCH_UPDATE;
    wire  [13:0] outs = {TEST_MODE, STROBE_SIGN, STROBE_MAG, STROBE_WORD,
                         DISPLACE_EARLY, DISPLACE_LATE, LOAD_COMPLETE};
    int   n_errors = 0;
    int   checks_done = 0;
    logic [5:0] words [6] = '{6'h1f, 6'h0f, 6'h10, 6'h20, 6'h01, 6'h15};
    logic [5:0] prev = 6'h00;

    always #20 CORE_CLK = ~CORE_CLK;

    wsc_host_model host (.link_clk(lclk), .ser_data(sdat), .load_en(len));

    wsc_strobe_ctrl #(.WORD_W(6)) dut (
        .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .LINK_CLK(lclk),
        .SERIAL_DATA(sdat), .REGISTER_LOAD_ENABLE(len),
        .STROBE_WORD(STROBE_WORD), .STROBE_SIGN(STROBE_SIGN),
        .STROBE_MAG(STROBE_MAG), .DISPLACE_EARLY(DISPLACE_EARLY),
        .DISPLACE_LATE(DISPLACE_LATE), .TEST_MODE(TEST_MODE),
        .LOAD_COMPLETE(LOAD_COMPLETE), .LATCH_UPDATE(LATCH_UPDATE));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [13:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [13:0] exp_out(input logic [5:0] w, input logic f);
        logic nz;
        nz = |w[3:0];
        return {w[5], w[4], w[3:0], w[4:0], nz & ~w[4], nz & w[4], f};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask

    // Raise enable, wait for the transfer pulse, then drop enable again
    task automatic xfer(input logic [5:0] w, input logic f);
        int k;
        k = 0;
        cyc(2);
        host.set_en(1'b1);
        while (LATCH_UPDATE !== 1'b1 && k < 10) begin
            cyc(1);
            k++;
        end
        chk("latch_update", {13'h0, k < 10}, 14'h1);
        chk("outputs", outs, exp_out(w, f));
        cyc(8);
        host.set_en(1'b0);
        cyc(8);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(4);
        RESET_N = 1'b1;
        cyc(3);
        chk("reset_outs", outs, 14'h0000);
        $display("test reset done");
        foreach (words[i]) begin
            host.shift({2'b00, words[i]}, 6);
            chk("latch_hold", {9'h0, STROBE_WORD}, {9'h0, prev[4:0]});
            xfer(words[i], 1'b1);
            prev = words[i];
            $display("test load %h done", words[i]);
        end
        // Shifts with enable high must not reach the stage
        host.set_en(1'b1);
        cyc(8);
        host.shift(8'hff, 6);
        cyc(8);
        host.set_en(1'b0);
        cyc(8);
        // Short frame on top of the kept word: three bits only, so not complete
        host.shift(8'h05, 3);
        xfer(6'h2d, 1'b0);
        $display("test frozen shift done");
        // Read pulses clock zeros in while the read gate is low
        host.shift(8'h00, 8);
        xfer(6'h00, 1'b1);
        $display("test hardwired done");
        close_out();
    end

    initial begin
        #100000;
        n_errors++;
        close_out();
    end
endmodule // tb_wsc_strobe_ctrl

// File: tb/wsc_host_model.sv
// Host model that loads the strobe control register over the three-wire link.
// Assumes the bench calls its tasks between core clock edges.
`timescale 1ns/1ps

module wsc_host_model (
    output logic link_clk,  // Runs only within a frame
    output logic ser_data,  // Serial bit, test bit goes first
    output logic load_en    // Low while shifting
);
    initial begin
        link_clk = 1'b0;
        ser_data = 1'b1;
        load_en  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sends bits n-1 down to 0 at a 12 ns link period
    task automatic shift(input logic [7:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            ser_data = bits[i];
            #6 link_clk = 1'b1;
            // Hold is over: stale data shows inverted, never a kind last value
            #1 ser_data = ~ser_data;
            #5 link_clk = 1'b0;
        end
    endtask

    task automatic set_en(input logic v);
        load_en = v;
    endtask
endmodule // wsc_host_model
